//--- rtl/sesp_eeprom_slave.sv
// Two-wire slave access logic of a 256-byte EEPROM with write protection
`timescale 1ns/1ps
`default_nettype none
module sesp_eeprom_slave #(
  parameter int PROG_CYC = sesp_pkg::PROG_CYCLES
) (
  // Clock and resets
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic nv_init,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Strap pins
  input wire logic chip_sel_bit0,
  input wire logic chip_sel_bit1,
  input wire logic chip_sel_bit2,
  input wire logic high_voltage_level,
  input wire logic write_inhibit_pin,
  // Status
  output logic prog_busy
);
  import sesp_pkg::*;

  typedef struct packed {
    logic [1:0] scl_sy;
    logic [1:0] sda_sy;
    logic [2:0] cs_sy0;
    logic [2:0] cs_sy1;
    logic [1:0] hv_sy;
    logic scl_d;
    logic sda_d;
    sesp_st_t st;
    logic [3:0] bcnt;
    logic ackph;
    logic [7:0] sh;
    logic rw;
    sesp_kind_t kind;
    logic dacked;
    logic [7:0] waddr;
    logic [7:0] raddr;
    logic [1:0][FIFO_W-1:0] fq;
    logic [1:0] fv;
    logic [PAGE_LEN-1:0][7:0] lat;
    logic [PAGE_LEN-1:0] lv;
    logic [3:0] page;
    logic [31:0] cnt;
    logic sda_oe;
    logic sda_o;
    logic busy;
  } sesp_state_t;

  sesp_state_t s_r;
  sesp_state_t s_nxt;

  // Storage that survives rst; only nv_init returns it to delivery state
  logic [7:0] mem [MEM_DEPTH];
  logic [MEM_DEPTH-1:0] blank_r;
  logic sw_prot_r;
  logic lock_r;

  logic commit;
  logic [7:0] rd_byte;
  logic [2:0] cs_pins;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic push;
  logic pop;
  logic [FIFO_W-1:0] push_word;
  logic fifo_full;
  logic ack;

  // The pin is tied low in use; protection never looks at it
  logic unused_inhibit;
  assign unused_inhibit = write_inhibit_pin;

  assign cs_pins = s_r.cs_sy1;
  assign scl_rise = s_r.scl_sy[1] & ~s_r.scl_d;
  assign scl_fall = ~s_r.scl_sy[1] & s_r.scl_d;
  assign start_ev = s_r.scl_sy[1] & s_r.scl_d & s_r.sda_d & ~s_r.sda_sy[1];
  assign stop_ev = s_r.scl_sy[1] & s_r.scl_d & ~s_r.sda_d & s_r.sda_sy[1];
  assign fifo_full = s_r.fv[1];
  // Unwritten bytes read as all ones
  assign rd_byte = blank_r[s_r.raddr] ? BLANK_BYTE : mem[s_r.raddr];
  // Programming ends only after the buffer has drained into the latches
  assign commit = (s_r.st == ST_PROG) && (s_r.fv == 2'b00) &&
                  (s_r.cnt == 32'h1);

  always_comb begin
    s_nxt = s_r;
    push = 1'b0;
    push_word = {4'h0, s_r.sh};
    ack = 1'b0;
    s_nxt.scl_sy = {s_r.scl_sy[0], scl_in};
    s_nxt.sda_sy = {s_r.sda_sy[0], sda_in};
    s_nxt.cs_sy0 = {chip_sel_bit2, chip_sel_bit1, chip_sel_bit0};
    s_nxt.cs_sy1 = s_r.cs_sy0;
    s_nxt.hv_sy = {s_r.hv_sy[0], high_voltage_level};
    s_nxt.scl_d = s_r.scl_sy[1];
    s_nxt.sda_d = s_r.sda_sy[1];
    s_nxt.sda_o = 1'b0;

    if (s_r.st == ST_PROG) begin
      // Bus lines are not looked at until the cycle is over
      s_nxt.sda_oe = 1'b0;
      if (s_r.fv == 2'b00) begin
        s_nxt.cnt = s_r.cnt - 32'h1;
      end
      if (commit) begin
        s_nxt.st = ST_IDLE;
        s_nxt.busy = 1'b0;
        s_nxt.lv = '0;
      end
    end else if (start_ev) begin
      s_nxt.st = ST_SEL;
      s_nxt.bcnt = 4'h0;
      s_nxt.ackph = 1'b0;
      s_nxt.sda_oe = 1'b0;
      s_nxt.dacked = 1'b0;
      if (s_r.kind != K_MEM) begin
        s_nxt.kind = K_MEM;
      end
    end else if (stop_ev) begin
      s_nxt.sda_oe = 1'b0;
      s_nxt.ackph = 1'b0;
      // Only a stop right after a data ack starts programming
      if (s_r.st == ST_WDAT && s_r.dacked && s_r.bcnt == 4'h1) begin
        s_nxt.st = ST_PROG;
        s_nxt.busy = 1'b1;
        s_nxt.cnt = 32'(PROG_CYC);
      end else begin
        s_nxt.st = ST_IDLE;
        s_nxt.lv = '0;
      end
    end else if (scl_rise && s_r.st != ST_IDLE) begin
      if (s_r.ackph) begin
        // Master leaves data line high: end of read
        if (s_r.st == ST_RDAT && s_r.sda_sy[1]) begin
          s_nxt.st = ST_IDLE;
          s_nxt.ackph = 1'b0;
        end
      end else begin
        s_nxt.bcnt = s_r.bcnt + 4'h1;
        if (s_r.st != ST_RDAT) begin
          s_nxt.sh = {s_r.sh[6:0], s_r.sda_sy[1]};
        end
      end
    end else if (scl_fall && (s_r.st != ST_IDLE || s_r.ackph)) begin
      // An ack given on the way to idle must still be released here,
      // else a protection read would hold the data line low for good
      if (s_r.ackph) begin
        s_nxt.ackph = 1'b0;
        s_nxt.bcnt = 4'h0;
        s_nxt.sda_oe = 1'b0;
        if (s_r.st == ST_RDAT) begin
          // Load the byte, then move the counter on, wrapping at FFh
          s_nxt.sh = rd_byte;
          s_nxt.raddr = s_r.raddr + 8'h1;
          s_nxt.sda_oe = ~rd_byte[7];
        end
      end else if (s_r.bcnt == BITS_PER_BYTE) begin
        s_nxt.ackph = 1'b1;
        case (s_r.st)
          ST_SEL: begin
            s_nxt.rw = s_r.sh[0];
            s_nxt.st = ST_IDLE;
            if (s_r.sh[7:4] == TYPE_MEM && s_r.sh[3:1] == cs_pins) begin
              ack = 1'b1;
              s_nxt.st = s_r.sh[0] ? ST_RDAT : ST_ADR;
              s_nxt.kind = K_MEM;
            end else if (s_r.sh[7:4] == TYPE_PROT && !lock_r) begin
              if (s_r.hv_sy[1] && s_r.sh[3:1] == CS_SET) begin
                ack = ~sw_prot_r;
                s_nxt.kind = K_SET;
              end else if (s_r.hv_sy[1] && s_r.sh[3:1] == CS_CLR) begin
                ack = 1'b1;
                s_nxt.kind = K_CLR;
              end else if (s_r.sh[3:1] == cs_pins) begin
                ack = 1'b1;
                s_nxt.kind = K_LOCK;
              end
              // Reads of protection state: ack select, data released
              if (ack && !s_r.sh[0]) begin
                s_nxt.st = ST_ADR;
              end
            end
          end
          ST_ADR: begin
            ack = 1'b1;
            s_nxt.st = ST_WDAT;
            if (s_r.kind == K_MEM) begin
              s_nxt.waddr = s_r.sh;
              s_nxt.raddr = s_r.sh;
              s_nxt.page = s_r.sh[7:4];
            end
          end
          ST_WDAT: begin
            if (s_r.kind != K_MEM) begin
              // Address and data contents are don't care
              ack = 1'b1;
            end else if (s_r.waddr <= PROT_LIMIT && (sw_prot_r || lock_r)) begin
              ack = 1'b0;
            end else if (!fifo_full) begin
              ack = 1'b1;
              push = 1'b1;
              push_word = {s_r.waddr[3:0], s_r.sh};
              // Wrap inside the page
              s_nxt.waddr = {s_r.waddr[7:4], s_r.waddr[3:0] + 4'h1};
            end
            s_nxt.dacked = ack;
            if (!ack) begin
              s_nxt.st = ST_IDLE;
              s_nxt.lv = '0;
            end
          end
          ST_RDAT: begin
            ack = 1'b0;
          end
          default: begin
            s_nxt.st = ST_IDLE;
          end
        endcase
        s_nxt.sda_oe = ack;
        if (s_r.st == ST_SEL && s_r.sh[0] && s_nxt.st == ST_ADR) begin
          s_nxt.st = ST_IDLE;
        end
      end else if (s_r.st == ST_RDAT) begin
        s_nxt.sda_oe = ~s_r.sh[3'(7 - s_r.bcnt)];
      end
      if (s_r.st == ST_SEL && s_r.bcnt == BITS_PER_BYTE && s_r.sh[0] &&
          s_r.sh[7:4] == TYPE_PROT && ack) begin
        s_nxt.st = ST_IDLE;
      end
    end

    // Two-entry buffer between the receiver and the page latches
    pop = s_r.fv[0] && !s_r.busy;
    if (s_r.st == ST_PROG) begin
      pop = s_r.fv[0];
    end
    if (pop) begin
      s_nxt.lat[s_r.fq[0][11:8]] = s_r.fq[0][7:0];
      s_nxt.lv[s_r.fq[0][11:8]] = 1'b1;
    end
    case ({push, pop})
      2'b10: begin
        s_nxt.fq[s_r.fv[0]] = push_word;
        s_nxt.fv[s_r.fv[0]] = 1'b1;
      end
      2'b01: begin
        s_nxt.fq[0] = s_r.fq[1];
        s_nxt.fv = {1'b0, s_r.fv[1]};
      end
      2'b11: begin
        s_nxt.fq[s_r.fv[1] ? 1 : 0] = push_word;
        if (s_r.fv[1]) begin
          s_nxt.fq[0] = s_r.fq[1];
        end
      end
      default: begin
        s_nxt.fv = s_nxt.fv;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
      s_r.scl_sy <= 2'h3;
      s_r.sda_sy <= 2'h3;
      s_r.scl_d <= 1'b1;
      s_r.sda_d <= 1'b1;
      s_r.st <= ST_IDLE;
      s_r.kind <= K_MEM;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Latched page goes to the array in one step at the end of the cycle
  always_ff @(posedge ref_clk) begin
    if (commit && s_r.kind == K_MEM) begin
      for (int i = 0; i < PAGE_LEN; i++) begin
        if (s_r.lv[i]) begin
          mem[{s_r.page, 4'(i)}] <= s_r.lat[i];
        end
      end
    end
  end

  // Protection and blank map are reset only by the delivery reset; the clear command also clears software protection
  always_ff @(posedge ref_clk or posedge nv_init) begin
    if (nv_init) begin
      blank_r <= '1;
      sw_prot_r <= 1'b0;
      lock_r <= 1'b0;
    end else if (commit) begin
      case (s_r.kind)
        K_SET: begin
          sw_prot_r <= 1'b1;
        end
        K_CLR: begin
          sw_prot_r <= 1'b0;
        end
        K_LOCK: begin
          lock_r <= 1'b1;
        end
        default: begin
          for (int i = 0; i < PAGE_LEN; i++) begin
            if (s_r.lv[i]) begin
              blank_r[{s_r.page, 4'(i)}] <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  assign sda_out = s_r.sda_o;
  assign sda_oe = s_r.sda_oe;
  assign prog_busy = s_r.busy;

endmodule : sesp_eeprom_slave
`default_nettype wire

//--- rtl/sesp_pkg.sv
// Constants and types for the serial EEPROM slave with write protection
package sesp_pkg;

  localparam int ADDR_W = 8;
  localparam int MEM_DEPTH = 256;
  localparam int PAGE_BITS = 4;
  localparam int PAGE_LEN = 16;
  localparam int FIFO_W = 12;

  localparam logic [3:0] TYPE_MEM = 4'ha;
  localparam logic [3:0] TYPE_PROT = 4'h6;
  localparam logic [2:0] CS_SET = 3'h1;
  localparam logic [2:0] CS_CLR = 3'h3;
  localparam logic [7:0] BLANK_BYTE = 8'hff;
  localparam logic [7:0] PROT_LIMIT = 8'h7f;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  localparam int CLK_PERIOD_PS = 4000;
  localparam longint PROG_TIME_NS = 5000000;
  // Longest time rounds down
  localparam longint PROG_CYCLES_L = (PROG_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int PROG_CYCLES = int'(PROG_CYCLES_L);

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_SEL = 6'h02,
    ST_ADR = 6'h04,
    ST_WDAT = 6'h08,
    ST_RDAT = 6'h10,
    ST_PROG = 6'h20
  } sesp_st_t;

  typedef enum logic [1:0] {
    K_MEM = 2'h0,
    K_SET = 2'h1,
    K_CLR = 2'h2,
    K_LOCK = 2'h3
  } sesp_kind_t;

endpackage : sesp_pkg

//--- test/sesp_chk.sv
// Pin-level assertion checker for the EEPROM slave
`timescale 1ns/1ps
`default_nettype none
module sesp_chk #(
  parameter int PROG_CYC = 20
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Bus and status
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic prog_busy
);
  int busy_r;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) busy_r <= 0;
    else busy_r <= prog_busy ? busy_r + 1 : 0;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  drain_only_a: assert property (sda_out == 1'b0)
    else $error("data output not open drain");
  busy_quiet_a: assert property (prog_busy |-> !sda_oe)
    else $error("data line driven while programming");
  busy_end_a: assert property ($fell(prog_busy) |-> !sda_oe)
    else $error("data line driven as programming ends");
  // Slack of one cycle for the registered busy flag
  busy_bound_a: assert property (busy_r <= PROG_CYC + 1)
    else $error("programming runs too long");
  busy_hold_a: assert property ($rose(prog_busy) |=> prog_busy[*8])
    else $error("programming cut short");
  stop_start_a: assert property ($rose(prog_busy) |->
    $past(scl_in) && $past(sda_in))
    else $error("programming started without stop");
  oe_rise_a: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("data line pulled while clock high");
  oe_fall_a: assert property ($fell(sda_oe) |-> !scl_in)
    else $error("data line released while clock high");
  cover property ($rose(prog_busy));
  cover property ($rose(sda_oe));
  cover property (prog_busy && !scl_in);
endmodule : sesp_chk
bind sesp_eeprom_slave sesp_chk #(.PROG_CYC(PROG_CYC)) chk_i (
  .ref_clk, .rst, .scl_in, .sda_in, .sda_out, .sda_oe, .prog_busy
);
`default_nettype wire

//--- test/sesp_eeprom_slave_tb.sv
// Self-checking bench for the EEPROM slave
`timescale 1ns/1ps
`default_nettype none
module sesp_eeprom_slave_tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic nv_init = 1'b1;
  logic cs0 = 1'b1;
  logic cs1 = 1'b0;
  logic cs2 = 1'b0;
  logic hv = 1'b0;
  logic wip = 1'b0;
  logic scl, sda_rel, sda_out, sda_oe, prog_busy;
  wire logic sda_line;
  int error_cnt = 0;
  int checked = 0;
  // Pull-up on the open-drain data line
  assign sda_line = sda_rel & ~sda_oe;
  always #2 ref_clk = ~ref_clk;
  sesp_master m (.ref_clk(ref_clk), .scl(scl), .sda_rel(sda_rel),
    .sda_line(sda_line));
  sesp_eeprom_slave #(.PROG_CYC(400)) uut (.ref_clk(ref_clk), .rst(rst),
    .nv_init(nv_init), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
    .sda_oe(sda_oe), .chip_sel_bit0(cs0), .chip_sel_bit1(cs1),
    .chip_sel_bit2(cs2), .high_voltage_level(hv),
    .write_inhibit_pin(wip), .prog_busy(prog_busy));
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task send(input logic [7:0] b, input logic e);
    logic a;
    m.wbyte(b, a);
    chk("ack", {7'h0, e}, {7'h0, a});
  endtask : send
  task probe(input logic [7:0] sel, input logic e);
    m.start();
    send(sel, e);
    m.stop();
  endtask : probe
  task prog(input logic e);
    int n;
    n = 0;
    repeat (10) @(negedge ref_clk);
    chk("busy", {7'h0, e}, {7'h0, prog_busy});
    while (prog_busy !== 1'b0 && n < 2000) begin
      @(negedge ref_clk);
      n++;
    end
    chk("idle", 8'h00, {7'h0, prog_busy});
  endtask : prog
  task wr(input logic [7:0] sel, adr, input logic [7:0] d[$],
    input logic la);
    m.start();
    send(sel, 1'b1);
    send(adr, 1'b1);
    foreach (d[i]) send(d[i], i < d.size() - 1 || la);
    m.stop();
  endtask : wr
  task rd(input logic [7:0] adr, input logic [7:0] e[$]);
    logic [7:0] b;
    m.start();
    send(8'ha2, 1'b1);
    send(adr, 1'b1);
    m.start();
    send(8'ha3, 1'b1);
    foreach (e[i]) begin
      m.rbyte(i < e.size() - 1, b);
      chk("rdata", e[i], b);
    end
    m.stop();
  endtask : rd
  task t_prot();
    rd(8'h40, '{8'hff});
    wr(8'ha2, 8'h00, '{8'ha5}, 1'b1);
    prog(1'b1);
    hv = 1'b1;
    wr(8'h62, 8'h00, '{8'h00}, 1'b1);
    prog(1'b1);
    hv = 1'b0;
    wip = 1'b1;
    wr(8'ha2, 8'h05, '{8'h77}, 1'b0);
    prog(1'b0);
    wip = 1'b0;
    wr(8'ha2, 8'h85, '{8'h77}, 1'b1);
    prog(1'b1);
    hv = 1'b1;
    cs1 = 1'b1;
    wr(8'h66, 8'h00, '{8'h00}, 1'b1);
    prog(1'b1);
    hv = 1'b0;
    cs1 = 1'b0;
    wr(8'ha2, 8'h05, '{8'h77}, 1'b1);
    prog(1'b1);
    wr(8'h62, 8'h00, '{8'h00}, 1'b1);
    prog(1'b1);
    hv = 1'b1;
    probe(8'h62, 1'b0);
    hv = 1'b0;
    // Bus reset must not touch stored protection
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    repeat (6) @(negedge ref_clk);
    wr(8'ha2, 8'h06, '{8'h11}, 1'b0);
    prog(1'b0);
    rd(8'h05, '{8'h77, 8'hff});
    rd(8'h85, '{8'h77});
    $display("test prot done");
  endtask : t_prot
  task t_page();
    logic [7:0] b;
    // Two bytes from the page's last address wrap once, never past start
    wr(8'ha2, 8'hff, '{8'hc3, 8'h3c}, 1'b1);
    probe(8'ha2, 1'b0);
    prog(1'b1);
    probe(8'ha2, 1'b1);
    rd(8'hff, '{8'hc3, 8'ha5});
    m.start();
    send(8'ha3, 1'b1);
    m.rbyte(1'b0, b);
    m.stop();
    chk("cur", 8'hff, b);
    rd(8'hf0, '{8'h3c, 8'hff});
    m.start();
    send(8'ha2, 1'b1);
    send(8'hf5, 1'b1);
    m.stop();
    prog(1'b0);
    probe(8'ha4, 1'b0);
    probe(8'h52, 1'b0);
    rd(8'hf5, '{8'hff});
    $display("test page done");
  endtask : t_page
  task summarize();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    nv_init = 1'b0;
    repeat (6) @(negedge ref_clk);
    t_prot();
    t_page();
    summarize();
  end
  initial begin
    repeat (60000) @(posedge ref_clk);
    error_cnt++;
    summarize();
  end
endmodule : sesp_eeprom_slave_tb
`default_nettype wire

//--- test/sesp_master.sv
// Bit-level two-wire bus master model
`timescale 1ns/1ps
`default_nettype none
module sesp_master (
  // Clock
  input wire logic ref_clk,
  // Bus
  output logic scl,
  output logic sda_rel,
  input wire logic sda_line
);
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // Quarter of the 80 ns bus period
  task q();
    repeat (5) @(negedge ref_clk);
  endtask : q
  task start();
    sda_rel = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_rel = 1'b0;
    q();
    scl = 1'b0;
  endtask : start
  task stop();
    sda_rel = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_rel = 1'b1;
    q();
  endtask : stop
  task bit_io(input logic b, output logic r);
    sda_rel = b;
    q();
    scl = 1'b1;
    q();
    r = sda_line;
    q();
    scl = 1'b0;
    q();
  endtask : bit_io
  task wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask : wbyte
  task rbyte(input logic mack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(!mack, r);
  endtask : rbyte
endmodule : sesp_master
`default_nettype wire
